/* File: include/nsd_pkg.sv */
// Package with constants and types for the node id strap decoder.
package nsd_pkg;
    localparam int unsigned CLK_HZ         = 20000000;
    localparam int unsigned ADC_W          = 12;
    localparam int unsigned CODE_W         = 3;
    localparam int unsigned NODE_W         = 9;
    localparam int unsigned NUM_STRAPS     = 3;
    // Converter full scale in millivolts; a code of all ones means this level.
    localparam int unsigned ADC_FS_MV      = 3300;
    localparam int unsigned THR_MV [7]     = '{530, 1410, 2010, 2430, 2750, 3010, 3220};
    localparam logic [8:0]  NODE_UNSET     = 9'h0ff;
    localparam logic [15:0] ALIAS_RST      = 16'h0000;
    localparam int unsigned SETTLE_US      = 100;
    localparam int unsigned SETTLE_CYC     = (SETTLE_US * (CLK_HZ / 1000000) > 0) ?
                                             SETTLE_US * (CLK_HZ / 1000000) : 1;
    localparam int unsigned BLINK_MS       = 1000;
    localparam int unsigned BLINK_CYC      = BLINK_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        NSD_ST_SETTLE = 2'b00,
        NSD_ST_SAMPLE = 2'b01,
        NSD_ST_DONE   = 2'b10
    } nsd_state_t;

    typedef struct packed {
        logic [CODE_W-1:0] high;
        logic [CODE_W-1:0] mid;
        logic [CODE_W-1:0] low;
    } nsd_codes_t;

    typedef struct packed {
        logic [NODE_W-1:0] node_number;
        logic [15:0]       station_alias;
        logic              vendor_can_protocol_mode;
        logic              lss_inactive;
        logic              from_hw;
    } nsd_result_t;
endpackage : nsd_pkg

/* File: rtl/nsd_strap_decoder.sv */
// Strap capture, quantizer and node number selection logic.
`timescale 1ns/1ns
`default_nettype none
module nsd_strap_decoder #(
    parameter int unsigned SETTLE_CYCLES = nsd_pkg::SETTLE_CYC,
    parameter int unsigned BLINK_CYCLES  = nsd_pkg::BLINK_CYC
) (
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_rst_n,
    input  wire logic [nsd_pkg::ADC_W-1:0]         i_adc_low,
    input  wire logic [nsd_pkg::ADC_W-1:0]         i_adc_mid,
    input  wire logic [nsd_pkg::ADC_W-1:0]         i_adc_high,
    input  wire logic                              i_variant_can,
    input  wire logic                              i_hw_select,
    input  wire logic                              i_setup_valid,
    input  wire logic [7:0]                        i_sw_node_number,
    input  wire logic                              i_node_addressing,
    output logic                                   o_valid,
    output nsd_pkg::nsd_codes_t                    o_codes,
    output nsd_pkg::nsd_result_t                   o_result,
    output logic                                   o_green_flash
);
    // Two-stage synchronisers; the converter output is not on this clock.
    logic [nsd_pkg::ADC_W-1:0] sy1_r [3];
    logic [nsd_pkg::ADC_W-1:0] sy2_r [3];
    logic [nsd_pkg::ADC_W-1:0] raw [3];
    logic [2:0]                code [3];
    assign raw[0] = i_adc_low;
    assign raw[1] = i_adc_mid;
    assign raw[2] = i_adc_high;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_strap
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sy1_r[g] <= '0;
                    sy2_r[g] <= '0;
                end else begin
                    sy1_r[g] <= raw[g];
                    sy2_r[g] <= sy1_r[g];
                end
            end
            // Each threshold is a constant product, so the seven comparators stay independent.
            logic [6:0] above;
            for (genvar t = 0; t < 7; t++) begin : g_thr
                assign above[t] = 32'(sy2_r[g]) * nsd_pkg::ADC_FS_MV >
                                  nsd_pkg::THR_MV[t] * ((32'd1 << nsd_pkg::ADC_W) - 32'd1);
            end

            // Count thresholds passed; ascending codes, eight intervals.
            always_comb begin
                code[g] = 3'h0;
                for (int k = 0; k < 7; k++) begin
                    if (above[k]) begin
                        code[g] = 3'(k + 1);
                    end
                end
            end
        end
    endgenerate

    nsd_pkg::nsd_state_t  state_r, state_nxt;
    logic [31:0]          settle_cnt_r, settle_cnt_nxt;
    nsd_pkg::nsd_codes_t  codes_r, codes_nxt;
    nsd_pkg::nsd_result_t res_r, res_nxt;
    logic                 valid_r, valid_nxt;
    logic [31:0]          blink_cnt_r, blink_cnt_nxt;
    logic                 flash_r, flash_nxt;
    logic                 capture_now;
    logic                 form_now;

    logic [8:0]           hw_node;
    logic                 all_zero;
    logic                 use_hw;
    logic                 unset;
    logic [8:0]           src_node;
    nsd_pkg::nsd_result_t res_calc;

    // Node source: straps, the stored number, or the unset default.
    always_comb begin
        // Bit 8 forced low: the top bit of the high code is dropped.
        hw_node  = {1'b0, codes_r.high[1:0], codes_r.mid, codes_r.low};
        all_zero = (codes_r == '0);
        use_hw   = i_hw_select || !i_setup_valid;
        unset    = use_hw && all_zero;
        if (unset) begin
            src_node = nsd_pkg::NODE_UNSET;
        end else if (use_hw) begin
            src_node = hw_node;
        end else begin
            src_node = {1'b0, i_sw_node_number};
        end
    end

    // Variant specific fields on top of the chosen node number.
    always_comb begin
        res_calc               = '0;
        res_calc.station_alias = nsd_pkg::ALIAS_RST;
        res_calc.from_hw       = use_hw;
        res_calc.node_number   = src_node;
        if (i_variant_can) begin
            if (unset) begin
                res_calc.lss_inactive = 1'b1;
            end else begin
                res_calc.vendor_can_protocol_mode = src_node[7];
                if (!src_node[7]) begin
                    res_calc.node_number = {2'b00, src_node[6:0]};
                end
            end
        end else if (i_node_addressing && src_node != nsd_pkg::NODE_UNSET) begin
            res_calc.station_alias = {7'h00, src_node};
        end
    end

    // Sequencer: settle, capture once, then park until the next reset.
    always_comb begin
        state_nxt      = state_r;
        settle_cnt_nxt = settle_cnt_r;
        case (state_r)
            nsd_pkg::NSD_ST_SETTLE: begin
                // Wait for dividers and synchronisers to settle after reset.
                if (settle_cnt_r >= SETTLE_CYCLES - 1) begin
                    settle_cnt_nxt = '0;
                    state_nxt      = nsd_pkg::NSD_ST_SAMPLE;
                end else begin
                    settle_cnt_nxt = settle_cnt_r + 32'd1;
                end
            end
            nsd_pkg::NSD_ST_SAMPLE: begin
                state_nxt = nsd_pkg::NSD_ST_DONE;
            end
            nsd_pkg::NSD_ST_DONE: begin
                // Only a reset leaves this state, so nothing is sampled twice.
                state_nxt = nsd_pkg::NSD_ST_DONE;
            end
            default: begin
                state_nxt = nsd_pkg::NSD_ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r      <= nsd_pkg::NSD_ST_SETTLE;
            settle_cnt_r <= '0;
        end else begin
            state_r      <= state_nxt;
            settle_cnt_r <= settle_cnt_nxt;
        end
    end

    assign capture_now = (state_r == nsd_pkg::NSD_ST_SAMPLE);
    assign form_now    = (state_r == nsd_pkg::NSD_ST_DONE) && !valid_r;

    // Codes are taken in the single sample state and never again before a reset.
    always_comb begin
        codes_nxt = codes_r;
        if (capture_now) begin
            codes_nxt = '{high: code[2], mid: code[1], low: code[0]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            codes_r <= '0;
        end else begin
            codes_r <= codes_nxt;
        end
    end

    // Results are formed once from the captured codes and then frozen.
    always_comb begin
        res_nxt   = res_r;
        valid_nxt = valid_r;
        if (form_now) begin
            res_nxt   = res_calc;
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            res_r   <= '0;
            valid_r <= 1'b0;
        end else begin
            res_r   <= res_nxt;
            valid_r <= valid_nxt;
        end
    end

    // A counter of its own keeps the flash period independent of the settle time.
    always_comb begin
        blink_cnt_nxt = blink_cnt_r;
        flash_nxt     = flash_r;
        if (res_r.lss_inactive) begin
            if (blink_cnt_r >= BLINK_CYCLES - 1) begin
                blink_cnt_nxt = '0;
                flash_nxt     = !flash_r;
            end else begin
                blink_cnt_nxt = blink_cnt_r + 32'd1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            blink_cnt_r <= '0;
            flash_r     <= 1'b0;
        end else begin
            blink_cnt_r <= blink_cnt_nxt;
            flash_r     <= flash_nxt;
        end
    end

    assign o_valid       = valid_r;
    assign o_codes       = codes_r;
    assign o_result      = res_r;
    assign o_green_flash = flash_r;
endmodule : nsd_strap_decoder
`default_nettype wire

/* File: verif/nsd_strap_model.sv */
// Resistive divider model that turns three interval codes into converter values.
`timescale 1ns/1ns
`default_nettype none
module nsd_strap_model (
    input  wire logic [8:0]  i_codes,
    output logic      [11:0] o_adc_low,
    output logic      [11:0] o_adc_mid,
    output logic      [11:0] o_adc_high
);
    // Interval centres keep each level clear of both neighbouring thresholds.
    localparam int NOM_MV [8] = '{0, 1060, 1760, 2250, 2600, 2890, 3130, 3290};
    function automatic logic [11:0] lvl(input logic [2:0] c);
        return 12'(NOM_MV[c] * 4095 / 3300);
    endfunction : lvl
    assign o_adc_low  = lvl(i_codes[2:0]);
    assign o_adc_mid  = lvl(i_codes[5:3]);
    assign o_adc_high = lvl(i_codes[8:6]);
endmodule : nsd_strap_model
`default_nettype wire

/* File: verif/nsd_strap_checker.sv */
// Concurrent checks on the strap decoder ports.
`timescale 1ns/1ns
`default_nettype none
module nsd_strap_checker #(parameter int unsigned SETTLE_CYCLES = 4) (
    input wire logic                 i_clk_sys,
    input wire logic                 i_rst_n,
    input wire logic                 i_variant_can,
    input wire logic                 i_hw_select,
    input wire logic                 i_setup_valid,
    input wire logic [7:0]           i_sw_node_number,
    input wire logic                 i_node_addressing,
    input wire logic                 o_valid,
    input wire nsd_pkg::nsd_codes_t  o_codes,
    input wire nsd_pkg::nsd_result_t o_result,
    input wire logic                 o_green_flash
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    int unsigned cnt_r;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) cnt_r <= 0;
        else if (!o_valid) cnt_r <= cnt_r + 1;
    end
    sequence s_hw_ready;
        o_valid && o_result.from_hw;
    endsequence
    a_valid_latency: assert property ($rose(o_valid) |-> cnt_r inside {[SETTLE_CYCLES+1:SETTLE_CYCLES+2]})
        else $error("result formed at wrong cycle");
    a_result_held: assert property (o_valid |=> o_valid && $stable(o_result) && $stable(o_codes))
        else $error("result changed before reset");
    a_node_bit8_zero: assert property (o_valid |-> !o_result.node_number[8])
        else $error("node bit 8 set");
    a_hw_node_sum: assert property (s_hw_ready and o_codes != 9'h000 |->
        o_result.node_number == {1'b0, o_codes.high[1:0], o_codes.mid, o_codes.low}) else $error("node sum wrong");
    a_zero_node: assert property (s_hw_ready and o_codes == 9'h000 |-> o_result.node_number == 9'h0ff)
        else $error("all zero node not 255");
    a_eth_alias: assert property (o_valid && !i_variant_can && i_node_addressing && o_result.node_number != 9'h0ff
        |-> o_result.station_alias == 16'(o_result.node_number)) else $error("alias not node");
    a_select_source: assert property (o_valid |-> o_result.from_hw == (i_hw_select || !i_setup_valid))
        else $error("wrong node source");
    a_can_vendor: assert property (o_valid && i_variant_can && !o_result.lss_inactive
        |-> o_result.vendor_can_protocol_mode == o_result.node_number[7]) else $error("vendor mode wrong");
    a_canopen_range: assert property (o_valid && i_variant_can && !o_result.vendor_can_protocol_mode
        && !o_result.lss_inactive |-> o_result.node_number < 9'd128) else $error("CANopen node above 127");
    a_lss_default: assert property (o_valid && i_variant_can && o_result.from_hw && o_codes == 9'h000
        |-> o_result.lss_inactive && !o_result.vendor_can_protocol_mode && o_result.node_number == 9'h0ff)
        else $error("unconfigured CAN default wrong");
    a_flash_idle: assert property (!o_result.lss_inactive |-> !o_green_flash)
        else $error("green flash outside LSS inactive");
endmodule : nsd_strap_checker
bind nsd_strap_decoder nsd_strap_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_nsd_strap_checker (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_variant_can(i_variant_can), .i_hw_select(i_hw_select),
    .i_setup_valid(i_setup_valid), .i_sw_node_number(i_sw_node_number), .i_node_addressing(i_node_addressing),
    .o_valid(o_valid), .o_codes(o_codes), .o_result(o_result), .o_green_flash(o_green_flash));
`default_nettype wire

/* File: verif/test_nsd_strap_decoder.sv */
// Self-checking bench for the strap decoder.
`timescale 1ns/1ns
`default_nettype none
module test_nsd_strap_decoder;
    logic                 clk = 0, rst_n = 0, can = 0, hw = 1, sv = 1, addr = 0, valid, flash;
    logic [8:0]           codes = 9'h000;
    logic [7:0]           sw = 8'h00;
    logic [11:0]          a_lo, a_mi, a_hi;
    nsd_pkg::nsd_codes_t  oc;
    nsd_pkg::nsd_result_t res;
    int                   errors = 0, samples_checked = 0;
    initial forever #25 clk = ~clk;
    nsd_strap_model i_nsd_strap_model (.i_codes(codes), .o_adc_low(a_lo), .o_adc_mid(a_mi), .o_adc_high(a_hi));
    nsd_strap_decoder #(.SETTLE_CYCLES(4), .BLINK_CYCLES(8)) i_nsd_strap_decoder (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_adc_low(a_lo), .i_adc_mid(a_mi), .i_adc_high(a_hi), .i_variant_can(can), .i_hw_select(hw),
        .i_setup_valid(sv), .i_sw_node_number(sw), .i_node_addressing(addr), .o_valid(valid), .o_codes(oc),
        .o_result(res), .o_green_flash(flash));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // Config is {can, hw select, setup valid, node addressing}; each run starts with a fresh reset.
    task automatic run(logic [8:0] c, logic [3:0] cfg, logic [7:0] s);
        logic [8:0] node;
        logic       useh, zero, f;
        int         t;
        @(negedge clk);
        rst_n = 0;
        codes = c;
        {can, hw, sv, addr} = cfg;
        sw = s;
        repeat (2) @(negedge clk);
        rst_n = 1;
        for (t = 0; t < 20 && valid !== 1'b1; t++) @(negedge clk);
        useh = cfg[2] || !cfg[1];
        zero = useh && c == 9'h000;
        node = useh ? 9'(64 * c[7:6] + 8 * c[5:3] + c[2:0]) : {1'b0, s};
        if (zero) node = 9'h0ff;
        chk("valid", 1, valid);
        chk("codes", c, oc);
        chk("node", node, res.node_number);
        if (!cfg[3]) chk("alias", (cfg[0] && node != 9'h0ff) ? node : 0, res.station_alias);
        if (cfg[3]) chk("vendor", !zero && node[7], res.vendor_can_protocol_mode);
        if (cfg[3]) chk("lss", zero, res.lss_inactive);
        if (cfg[3] && zero) begin
            t = 0;
            f = flash;
            repeat (40) begin
                @(negedge clk);
                if (flash !== f) t++;
                f = flash;
            end
            chk("flash toggles", 1, t > 3 && t < 7);
        end
        codes = ~c;
        repeat (4) @(negedge clk);
        chk("held node", node, res.node_number);
        $display("Test done codes %h config %b", c, cfg);
    endtask : run
    initial begin
        for (int k = 0; k < 8; k++) run({6'o01, 3'(k)}, 4'b0100, 8'h00);
        run(9'o753, 4'b0101, 8'h00);
        run(9'o000, 4'b0101, 8'h00);
        run(9'o124, 4'b0011, 8'h2a);
        run(9'o124, 4'b0000, 8'h2a);
        run(9'o267, 4'b1100, 8'h00);
        run(9'o124, 4'b1010, 8'hc5);
        run(9'o124, 4'b1010, 8'h35);
        run(9'o123, 4'b1100, 8'h00);
        run(9'o000, 4'b1100, 8'h00);
        give_verdict();
    end
    // Runs need well under 2000 cycles; a hang ends the run through the same verdict.
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
endmodule : test_nsd_strap_decoder
`default_nettype wire
